// ===== hw/mmas_map.svh
// constants of the main memory array select block
// assumes inclusion by bare name from the package and the design files
`ifndef MMAS_MAP_SVH
`define MMAS_MAP_SVH

// ************************************************************
// array geometry
// ************************************************************
`define MMAS_DATA_BITS 17
`define MMAS_LOWER_CARD_TOP 9
`define MMAS_MODULE_COUNT 12
`define MMAS_LOW_DECODER_MODULES 8
`define MMAS_BANKS 4
`define MMAS_CHIP_DEPTH 1024
`define MMAS_CHIP_ADDR_BITS 10

// ************************************************************
// address field positions
// ************************************************************
`define MMAS_ADDR_TOP 16
`define MMAS_MODULE_ADDR_LOW 5
`define MMAS_BANK_ADDR_LOW 5
`define MMAS_BANK_ADDR_HIGH 6
`define MMAS_CELL_ADDR_LOW 7
`define MMAS_DECODE_BANK_BIT 1
`define MMAS_DECODE_CODE_LOW 2
`define MMAS_DECODE_CODE_HIGH 4

// ************************************************************
// reset values
// ************************************************************
`define MMAS_RESET_SELECT 12'h000
`define MMAS_RESET_DATA 17'h00000
`define MMAS_RESET_ADDRESS 12'h000

`endif

// ===== hw/mmas_pkg.sv
// types shared by the main memory array select design files
// assumes mmas_map.svh on the include path
`include "mmas_map.svh"

package mmas_pkg;

  // ************************************************************
  // request carrier from the shared memory unit
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic writeStrobeN;
    logic [`MMAS_ADDR_TOP:1] sharedAddressN;
    logic [`MMAS_DATA_BITS:1] writeData;
  } mmas_req_t;

  // ************************************************************
  // state of one storage chip
  // ************************************************************
  typedef struct packed {
    logic dataOut;
    logic dataOutEn;
  } mmas_chip_state_t;

  // ************************************************************
  // state of the array top
  // ************************************************************
  typedef struct packed {
    logic [`MMAS_ADDR_TOP:`MMAS_MODULE_ADDR_LOW] moduleAddress;
    logic [`MMAS_MODULE_COUNT:1] moduleSelect;
    logic [`MMAS_DATA_BITS:1] moduleWriteData;
    logic moduleWriteStrobeN;
    logic standbyWriteInhibit;
    logic [`MMAS_MODULE_COUNT:1] readSelect;
    logic readPending;
    logic [`MMAS_DATA_BITS:1] readDataBus;
    logic readValid;
  } mmas_state_t;

endpackage

// ===== hw/mmas_storage_chip.sv
// one static storage chip: 1024 one-bit cells, low-active chip select
// assumes synchronous inputs on sys_clk; the caller forms the wired-or
`timescale 1ns/100ps
`default_nettype none
`include "mmas_map.svh"

module mmas_storage_chip #(
  parameter int DEPTH = `MMAS_CHIP_DEPTH,
  parameter int AW = `MMAS_CHIP_ADDR_BITS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic chipSelectN,
  input wire logic readWriteN,
  input wire logic [AW-1:0] cellAddr,
  input wire logic cellWriteBit,
  output logic dataOut,
  output logic dataOutEn
);
  import mmas_pkg::*;

  mmas_chip_state_t st_r;
  mmas_chip_state_t st_nxt;
  logic cells [DEPTH];

  // ************************************************************
  // cell array
  // ************************************************************
  // no reset on the cells: contents are kept like a static part
  always_ff @(posedge sys_clk) begin
    if (!chipSelectN && !readWriteN) begin
      cells[cellAddr] <= cellWriteBit; // RULE5
    end
  end

  // ************************************************************
  // output stage
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.dataOutEn = !chipSelectN; // RULE1
    st_nxt.dataOut = 1'b0;
    if (!chipSelectN) begin
      if (readWriteN) begin // RULE2
        st_nxt.dataOut = cells[cellAddr]; // RULE3 RULE4
      end else begin
        st_nxt.dataOut = cellWriteBit; // RULE5
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dataOut = st_r.dataOut;
  assign dataOutEn = st_r.dataOutEn;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_write_cell;
    !chipSelectN && !readWriteN;
  endsequence

  sequence s_read_same;
    !chipSelectN && readWriteN && (cellAddr == $past(cellAddr));
  endsequence

  property p_idle_quiet;
    chipSelectN |=> !dataOutEn;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("deselected chip drives output"); // RULE1

  property p_selected_drives;
    !chipSelectN |=> dataOutEn;
  endproperty
  a_selected_drives: assert property (p_selected_drives) else $error("selected chip silent"); // RULE2

  property p_write_echo;
    s_write_cell |=> (dataOut == $past(cellWriteBit));
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("write bit not echoed"); // RULE5

  property p_read_back;
    s_write_cell ##1 s_read_same |=> (dataOut == $past(cellWriteBit, 2));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read differs from stored bit"); // RULE3

endmodule

`default_nettype wire

// ===== hw/mmas_main_memory.sv
// main memory array: driver cards, twelve 4K modules and output buffer
// assumes one request per cycle on req, synchronous to sys_clk
//
// Summary of operation
// RULE1: deselected chip neither reads, writes nor drives
// RULE2: selected chip obeys its read/write input
// RULE3: read presents addressed cell without disturbing it
// RULE4: ten address bits pick one of 1024 cells
// RULE5: write stores bit and echoes it noninverted
// RULE6: sixteen data bits plus parity pass straight through
// RULE7: address lines sixteen to five inverted forward
// RULE8: lines one to four select one module
// RULE9: line one high: modules one to eight
// RULE10: line one low: modules nine to twelve
// RULE11: bits one-nine lower card, ten-seventeen upper
// RULE12: module address five, six pick chip bank
// RULE13: module address sixteen to seven pick cell
// RULE14: module drives read lines only when selected
// RULE15: write needs select high and strobe low
// RULE16: output buffer inverts read lines to bus
// RULE17: standby inhibit blocks first module writes
// RULE18: codes beyond twelve select no module
`timescale 1ns/100ps
`default_nettype none
`include "mmas_map.svh"

module mmas_main_memory #(
  parameter int MODULES = `MMAS_MODULE_COUNT,
  parameter int BANKS = `MMAS_BANKS,
  parameter int DEPTH = `MMAS_CHIP_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire mmas_pkg::mmas_req_t req,
  input wire logic standbyMode,
  input wire logic powerTransition,
  output logic [`MMAS_ADDR_TOP:`MMAS_MODULE_ADDR_LOW] moduleAddress,
  output logic [`MMAS_MODULE_COUNT:1] moduleSelect,
  output logic standbyWriteInhibit,
  output logic [`MMAS_DATA_BITS:1] readDataBus,
  output logic readValid
);
  import mmas_pkg::*;

  localparam int DB = `MMAS_DATA_BITS;
  localparam int AW = `MMAS_CHIP_ADDR_BITS;

  mmas_state_t st_r;
  mmas_state_t st_nxt;

  logic [BANKS-1:0][DB:1] chipOut [1:MODULES];
  logic [BANKS-1:0][DB:1] chipEn [1:MODULES];
  logic [MODULES:1] writeGate;
  logic [DB:1] moduleReadDataN;
  logic [AW-1:0] cellAddr;
  logic [1:0] bankCode;

  // ************************************************************
  // module select decode
  // ************************************************************
  // two 3-to-8 decoders: the raw low-active code drives the decoder,
  // its low-active output is then inverted into a high module select
  function automatic logic [`MMAS_MODULE_COUNT:1] decodeSelect(
    input logic [`MMAS_DECODE_CODE_HIGH:`MMAS_DECODE_BANK_BIT] lineN
  );
    logic [2:0] code;
    logic [`MMAS_MODULE_COUNT:1] sel;
    code = lineN[`MMAS_DECODE_CODE_HIGH:`MMAS_DECODE_CODE_LOW];
    sel = `MMAS_RESET_SELECT;
    if (lineN[`MMAS_DECODE_BANK_BIT]) begin // RULE9
      sel[4'(code) + 4'h1] = 1'b1;
    end else if (code < 3'h4) begin // RULE10
      sel[4'(code) + 4'h9] = 1'b1;
    end
    // remaining codes leave every module idle // RULE18
    return sel;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    // driver cards: one stage of input registers
    st_nxt.moduleAddress =
      ~req.sharedAddressN[`MMAS_ADDR_TOP:`MMAS_MODULE_ADDR_LOW]; // RULE7
    st_nxt.moduleWriteData = req.writeData; // RULE6
    st_nxt.moduleWriteStrobeN = !req.valid || req.writeStrobeN;
    st_nxt.moduleSelect = `MMAS_RESET_SELECT;
    if (req.valid) begin
      st_nxt.moduleSelect =
        decodeSelect(req.sharedAddressN[`MMAS_DECODE_CODE_HIGH:`MMAS_DECODE_BANK_BIT]); // RULE8
    end
    // held for the same cycle as the write it must guard
    st_nxt.standbyWriteInhibit = standbyMode && powerTransition; // RULE17
    // chip stage: remember which module answers the read
    st_nxt.readSelect = st_r.moduleSelect;
    st_nxt.readPending = (|st_r.moduleSelect) && st_r.moduleWriteStrobeN;
    // output buffer stage
    st_nxt.readValid = st_r.readPending;
    st_nxt.readDataBus = `MMAS_RESET_DATA;
    if (st_r.readPending) begin
      st_nxt.readDataBus = ~moduleReadDataN; // RULE16
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // write gating and chip addressing
  // ************************************************************
  always_comb begin
    for (int m = 1; m <= MODULES; m++) begin
      writeGate[m] = st_r.moduleSelect[m] && !st_r.moduleWriteStrobeN; // RULE15
    end
    // only the first module keeps the preserved contents
    writeGate[1] = writeGate[1] && !st_r.standbyWriteInhibit; // RULE17
  end

  assign cellAddr = st_r.moduleAddress[`MMAS_ADDR_TOP:`MMAS_CELL_ADDR_LOW]; // RULE13
  assign bankCode = st_r.moduleAddress[`MMAS_BANK_ADDR_HIGH:`MMAS_BANK_ADDR_LOW]; // RULE12

  // ************************************************************
  // storage modules
  // ************************************************************
  // bits up to the lower card top sit on the lower bit card,
  // the rest on the upper bit card; both share one chip layout
  for (genvar m = 1; m <= MODULES; m++) begin : g_module
    for (genvar k = 0; k < BANKS; k++) begin : g_bank
      for (genvar b = 1; b <= DB; b++) begin : g_bit // RULE11
        mmas_storage_chip #(
          .DEPTH(DEPTH),
          .AW(AW)
        ) u_chip (
          .sys_clk(sys_clk),
          .rst_b(rst_b),
          .chipSelectN(!(st_r.moduleSelect[m] && (bankCode == 2'(k)))), // RULE12
          .readWriteN(!writeGate[m]),
          .cellAddr(cellAddr),
          .cellWriteBit(st_r.moduleWriteData[b]),
          .dataOut(chipOut[m][k][b]),
          .dataOutEn(chipEn[m][k][b])
        );
      end
    end
  end

  // ************************************************************
  // wired-or read lines
  // ************************************************************
  // tri-state tie modelled as and-or; a module pulls its low-active
  // read line only while its select from the access cycle stands
  always_comb begin
    moduleReadDataN = '1;
    for (int m = 1; m <= MODULES; m++) begin
      for (int b = 1; b <= DB; b++) begin
        for (int k = 0; k < BANKS; k++) begin
          if (st_r.readSelect[m] && chipEn[m][k][b] && chipOut[m][k][b]) begin // RULE14
            moduleReadDataN[b] = 1'b0;
          end
        end
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign moduleAddress = st_r.moduleAddress;
  assign moduleSelect = st_r.moduleSelect;
  assign standbyWriteInhibit = st_r.standbyWriteInhibit;
  assign readDataBus = st_r.readDataBus;
  assign readValid = st_r.readValid;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // only codes that select a module answer a read
  sequence s_read_taken;
    req.valid && req.writeStrobeN && (req.sharedAddressN[1] || !req.sharedAddressN[4]);
  endsequence

  sequence s_read_refused;
    req.valid && req.writeStrobeN && !req.sharedAddressN[1] && req.sharedAddressN[4];
  endsequence

  sequence s_write_kept;
    req.valid && !req.writeStrobeN && !(standbyMode && powerTransition) &&
      (req.sharedAddressN[1] || !req.sharedAddressN[4]);
  endsequence

  sequence s_read_again;
    req.valid && req.writeStrobeN && (req.sharedAddressN == $past(req.sharedAddressN));
  endsequence

  property p_addr_invert;
    req.valid |=> (moduleAddress == ~$past(req.sharedAddressN[16:5]));
  endproperty
  a_addr_invert: assert property (p_addr_invert) else $error("module address not inverted"); // RULE7

  property p_data_pass;
    req.valid |=> (st_r.moduleWriteData == $past(req.writeData));
  endproperty
  a_data_pass: assert property (p_data_pass) else $error("write data altered"); // RULE6

  property p_one_module;
    $onehot0(moduleSelect);
  endproperty
  a_one_module: assert property (p_one_module) else $error("several modules selected"); // RULE8

  property p_low_decoder;
    req.valid && req.sharedAddressN[1] && (req.sharedAddressN[4:2] == 3'h5)
      |=> (moduleSelect == 12'h020);
  endproperty
  a_low_decoder: assert property (p_low_decoder) else $error("low decoder wrong module"); // RULE9

  property p_high_decoder;
    req.valid && !req.sharedAddressN[1] && (req.sharedAddressN[4:2] == 3'h3)
      |=> (moduleSelect == 12'h800);
  endproperty
  a_high_decoder: assert property (p_high_decoder) else $error("high decoder wrong module"); // RULE10

  property p_no_module;
    req.valid && !req.sharedAddressN[1] && req.sharedAddressN[4]
      |=> (moduleSelect == 12'h000);
  endproperty
  a_no_module: assert property (p_no_module) else $error("module beyond twelve selected"); // RULE18

  property p_read_latency;
    s_read_taken |-> ##3 readValid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data not on time"); // RULE16

  property p_inhibit;
    standbyMode && powerTransition |=> standbyWriteInhibit && !writeGate[1];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("first module writable in standby"); // RULE17

  property p_write_gate;
    (|writeGate) |-> !st_r.moduleWriteStrobeN && ((writeGate & ~moduleSelect) == 12'h000);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write without select and strobe"); // RULE15

  property p_first_module;
    req.valid && req.sharedAddressN[1] && (req.sharedAddressN[4:2] == 3'h0)
      |=> (moduleSelect == 12'h001);
  endproperty
  a_first_module: assert property (p_first_module) else $error("module one not chosen"); // RULE9

  property p_ninth_module;
    req.valid && !req.sharedAddressN[1] && (req.sharedAddressN[4:2] == 3'h0)
      |=> (moduleSelect == 12'h100);
  endproperty
  a_ninth_module: assert property (p_ninth_module) else $error("module nine not chosen"); // RULE10

  property p_select_idle;
    !req.valid |=> (moduleSelect == 12'h000);
  endproperty
  a_select_idle: assert property (p_select_idle) else $error("select without request"); // RULE8

  property p_bank_field;
    req.valid |=> (bankCode == ~$past(req.sharedAddressN[6:5]));
  endproperty
  a_bank_field: assert property (p_bank_field) else $error("chip bank field wrong"); // RULE12

  property p_cell_field;
    req.valid |=> (cellAddr == ~$past(req.sharedAddressN[16:7]));
  endproperty
  a_cell_field: assert property (p_cell_field) else $error("cell address field wrong"); // RULE13

  property p_read_no_write;
    s_read_taken |=> !(|writeGate);
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read request wrote a cell"); // RULE15

  property p_inhibit_clear;
    !(standbyMode && powerTransition) |=> !standbyWriteInhibit;
  endproperty
  a_inhibit_clear: assert property (p_inhibit_clear) else $error("inhibit outside standby"); // RULE17

  property p_bus_quiet;
    !readValid |-> (readDataBus == 17'h00000);
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("read bus driven without read"); // RULE14

  // write then read of one location: the bus must show the written word
  property p_read_after_write;
    s_write_kept ##1 s_read_again |-> ##3 (readDataBus == $past(req.writeData, 4));
  endproperty
  a_read_after_write: assert property (p_read_after_write) else $error("stored word lost"); // RULE15

  property p_refused_read;
    s_read_refused |-> ##3 !readValid;
  endproperty
  a_refused_read: assert property (p_refused_read) else $error("idle code answered read"); // RULE18

  property p_inhibit_spares;
    standbyMode && powerTransition && req.valid && !req.writeStrobeN &&
      req.sharedAddressN[1] && (req.sharedAddressN[4:2] == 3'h1)
      |=> writeGate[2];
  endproperty
  a_inhibit_spares: assert property (p_inhibit_spares) else $error("inhibit hit module two"); // RULE17

endmodule

`default_nettype wire

// ===== verif/mmas_shared_unit.sv
// model of the shared memory unit and loader feeding the array request
// assumes bench commands change on the rising edge; the request moves on the falling one
`timescale 1ns/100ps
`default_nettype none

module mmas_shared_unit (
  input wire logic sys_clk,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [16:1] cmdAddrN,
  input wire logic [16:1] cmdData,
  input wire logic cmdParity,
  output var mmas_pkg::mmas_req_t req
);
  import mmas_pkg::*;

  // ************************************************************
  // request drive
  // ************************************************************
  initial req = {1'h0, 1'h1, 16'hFFFF, 17'h00000};

  always @(negedge sys_clk) begin
    req.valid <= cmdValid;
    if (cmdValid) begin
      req.writeStrobeN <= ~cmdWrite;
      req.sharedAddressN <= cmdAddrN;
      req.writeData <= {cmdParity, cmdData};
    end else begin
      // idle lines flip so stale values never pass for a request
      req.writeStrobeN <= ~req.writeStrobeN;
      req.sharedAddressN <= ~req.sharedAddressN;
      req.writeData <= ~req.writeData;
    end
  end
endmodule

`default_nettype wire

// ===== verif/test_mmas_main_memory.sv
// self-checking bench of the main memory array select block
// assumes mmas_pkg compiled first; partner model drives the request
`timescale 1ns/100ps
`default_nettype none

module test_mmas_main_memory;
  import mmas_pkg::*;
  typedef struct packed {
    logic [12:1] sel;
    logic [16:5] adr;
    logic inh;
  } mmas_exp_t;

  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic cmdValid = 1'h0;
  logic cmdWrite = 1'h0;
  logic [16:1] cmdAddrN = 16'hFFFF;
  logic [16:1] cmdData = 16'h0000;
  logic cmdParity = 1'h0;
  logic standbyMode = 1'h0;
  logic powerTransition = 1'h0;
  mmas_req_t req;
  logic [16:5] moduleAddress;
  logic [12:1] moduleSelect;
  logic standbyWriteInhibit;
  logic [17:1] readDataBus;
  logic readValid;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] rnd = 16'h0030;
  logic [17:1] shadow [int];
  mmas_exp_t selQ [$];
  logic [17:1] rdQ [$];
  mmas_exp_t e;
  logic took = 1'h0;
  logic [9:0] cells [4];
  logic [9:0] c;
  logic [1:0] bk;
  int m;

  always #5 sys_clk = ~sys_clk;

  mmas_shared_unit u_unit (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddrN(cmdAddrN), .cmdData(cmdData), .cmdParity(cmdParity), .req(req));

  mmas_main_memory u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
    .standbyMode(standbyMode), .powerTransition(powerTransition),
    .moduleAddress(moduleAddress), .moduleSelect(moduleSelect),
    .standbyWriteInhibit(standbyWriteInhibit), .readDataBus(readDataBus),
    .readValid(readValid));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // modules 13 to 16 land on the unused decoder outputs
  function automatic logic [16:1] lines(input int mm, input logic [1:0] b, input logic [9:0] cl);
    logic [3:0] code;
    code = (mm <= 8) ? 4'(mm - 1) : 4'(mm - 9);
    return {~cl, ~b, code[2:0], 1'(mm <= 8)};
  endfunction

  task automatic fail(input logic [17:1] exp, input logic [17:1] got);
    error_cnt++;
    $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
  endtask

  task automatic cmpSel(input logic [12:1] exp, input logic [12:1] got);
    num_checks++;
    if (got !== exp) fail({5'h00, exp}, {5'h00, got});
  endtask

  task automatic cmpData(input logic [17:1] exp, input logic [17:1] got);
    num_checks++;
    if (got !== exp) fail(exp, got);
  endtask

  task automatic op(input logic wr, input int mm, input logic [1:0] b, input logic [9:0] cl,
                    input logic s, input logic p);
    logic [17:1] d;
    int key;
    mmas_exp_t x;
    rnd = lfsr(rnd);
    d[16:1] = rnd;
    rnd = lfsr(rnd);
    d[17] = rnd[0];
    key = mm * 4096 + int'({cl, b});
    x.sel = 12'h000;
    if (mm <= 12) x.sel[mm] = 1'h1;
    x.adr = {cl, b};
    x.inh = s & p;
    @(posedge sys_clk);
    cmdValid <= 1'h1;
    cmdWrite <= wr;
    cmdAddrN <= lines(mm, b, cl);
    cmdData <= d[16:1];
    cmdParity <= d[17];
    @(negedge sys_clk);
    standbyMode <= s;
    powerTransition <= p;
    selQ.push_back(x);
    if (mm <= 12 && wr && !(mm == 1 && s && p)) shadow[key] = d;
    if (mm <= 12 && !wr) rdQ.push_back(shadow[key]);
  endtask

  task automatic idle(input int n);
    @(posedge sys_clk);
    cmdValid <= 1'h0;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ************************************************************
  // output watcher
  // ************************************************************
  always @(posedge sys_clk) took <= req.valid & rst_b;

  always @(negedge sys_clk) begin
    if (rst_b) begin
      if (took) begin
        e = selQ.pop_front();
        cmpSel(e.sel, moduleSelect);
        cmpSel(e.adr, moduleAddress);
        cmpSel({11'h000, e.inh}, {11'h000, standbyWriteInhibit});
      end else begin
        cmpSel(12'h000, moduleSelect);
      end
      if (readValid !== 1'h1) begin
        cmpData(17'h00000, readDataBus);
      end else if (rdQ.size() == 0) begin
        fail(17'h00000, readDataBus);
      end else begin
        cmpData(rdQ.pop_front(), readDataBus);
      end
    end
  end

  // ************************************************************
  // stimulus
  // ************************************************************
  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b <= 1'h1;
    for (int b = 0; b < 4; b++) begin
      rnd = lfsr(rnd);
      cells[b] = rnd[9:0];
    end
    // same cell in every module: a stray select overwrites a neighbour
    for (int b = 0; b < 4; b++) for (int k = 1; k <= 12; k++) op(1'h1, k, 2'(b), cells[b], 1'h0, 1'h0);
    for (int b = 0; b < 4; b++) for (int k = 1; k <= 12; k++) op(1'h0, k, 2'(b), cells[b], 1'h0, 1'h0);
    for (int k = 13; k <= 16; k++) begin
      op(1'h1, k, 2'h0, cells[0], 1'h0, 1'h0);
      op(1'h0, k, 2'h0, cells[0], 1'h0, 1'h0);
    end
    idle(4);
    for (int k = 1; k <= 12; k++) op(1'h0, k, 2'h0, cells[0], 1'h0, 1'h0);
    // standby inhibit must spare every module but the first
    op(1'h1, 1, 2'h1, cells[1], 1'h1, 1'h1);
    op(1'h1, 2, 2'h1, cells[1], 1'h1, 1'h1);
    op(1'h1, 1, 2'h2, cells[2], 1'h1, 1'h0);
    op(1'h1, 1, 2'h3, cells[3], 1'h0, 1'h1);
    op(1'h0, 1, 2'h1, cells[1], 1'h0, 1'h0);
    op(1'h0, 1, 2'h1, cells[1], 1'h0, 1'h0);
    op(1'h0, 2, 2'h1, cells[1], 1'h0, 1'h0);
    op(1'h0, 1, 2'h2, cells[2], 1'h0, 1'h0);
    op(1'h0, 1, 2'h3, cells[3], 1'h0, 1'h0);
    repeat (24) begin
      rnd = lfsr(rnd);
      m = 1 + int'(rnd[3:0]) % 12;
      c = rnd[13:4];
      // op advances rnd, so the bank is held for the read back
      bk = rnd[15:14];
      op(1'h1, m, bk, c, 1'h0, 1'h0);
      op(1'h0, m, bk, c, 1'h0, 1'h0);
    end
    idle(6);
    if (rdQ.size() != 0) fail(17'(rdQ.size()), 17'h00000);
    complete_run();
  end

  // traffic is near 200 cycles; the limit leaves a wide margin
  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end
endmodule

`default_nettype wire
